/* File: tb/tb_top.sv */
// Self-checking bench of the watchdog option block over its Avalon-MM port.
// Assumes one wait state per request; reads are checked from a queue of notes.
`timescale 1ns/100ps
`include "wdo_params.svh"
module tb_top;
    localparam logic [13:0] RL [4] = '{`WDO_RELOAD_0, `WDO_RELOAD_1, `WDO_RELOAD_2, `WDO_RELOAD_3};
    logic clock = 0, rst_n = 0, avsRead = 0, avsWrite = 0, lowSpeedClkPin = 0;
    logic resetOptErased = 0, wdogOptErased = 0;
    logic [17:0] avsAddress = 0;
    logic [31:0] avsWritedata = 0, avsReaddata;
    logic [3:0] avsByteenable = 4'hF;
    logic [7:0] resetOptionPin = 8'hFF, watchdogOptionPin = 8'hFF, ro, wo, r, w;
    logic avsWaitrequest, irq, wdogResetReq, countSourceLow, codeProtectOn;
    logic voltMonitorOn, wdogRunning;
    logic [13:0] reloadCount;
    logic [1:0] refreshWindowSel, detectLevelSel;
    logic [31:0] expQ [$];
    int fails = 0, totalChecks = 0, cyc = 0, t0;

    wdo_option_config DUT (.clock(clock), .rst_n(rst_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .resetOptionPin(resetOptionPin),
        .watchdogOptionPin(watchdogOptionPin), .resetOptErased(resetOptErased),
        .wdogOptErased(wdogOptErased), .lowSpeedClkPin(lowSpeedClkPin), .irq(irq),
        .wdogResetReq(wdogResetReq), .countSourceLow(countSourceLow),
        .reloadCount(reloadCount), .refreshWindowSel(refreshWindowSel),
        .codeProtectOn(codeProtectOn), .detectLevelSel(detectLevelSel),
        .voltMonitorOn(voltMonitorOn), .wdogRunning(wdogRunning));

    always #25 clock = ~clock;

    // Timeout well above the one long wait of about 16k cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        lowSpeedClkPin <= cyc[3];
        if (cyc == 60000) begin
            fails++;
            end_sim();
        end
    end

    always @(posedge clock)
        if (avsRead && !avsWaitrequest) chk("readdata", expQ.pop_front(), avsReaddata);

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(logic wr, logic [15:0] idx, logic [31:0] d);
        @(posedge clock);
        avsAddress <= {idx, 2'b00};
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge clock); while (avsWaitrequest !== 1'b0);
        avsWrite <= 0;
        avsRead <= 0;
    endtask

    task automatic rd(logic [15:0] idx, logic [31:0] e);
        expQ.push_back(e);
        bus(0, idx, 0);
    endtask

    // Pins change only inside reset, as the flash would
    task automatic boot(logic [7:0] rp, logic [7:0] wp, logic er);
        rst_n <= 0;
        resetOptionPin <= rp;
        watchdogOptionPin <= wp;
        resetOptErased <= er;
        wdogOptErased <= er;
        ro = er ? 8'hFF : rp;
        wo = er ? 8'hFF : wp;
        repeat (6) @(posedge clock);
        rst_n <= 1;
        repeat (5) @(posedge clock);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h8836));
        for (int i = 0; i < 5; i++) begin
            r = 8'($urandom);
            w = 8'($urandom);
            r[5:4] = 2'(i);
            w[1:0] = 2'(i);
            w[3:2] = ~2'(i);
            r[1] = 1'b1;
            w[7:4] = 4'hF;
            boot(r, w, i == 4);
            chk("options", 32'({RL[wo[1:0]], wo[3:2], ro[2] & ~ro[3], ro[5:4], ~ro[6], ~ro[0],
                ~ro[7]}), 32'({reloadCount, refreshWindowSel, codeProtectOn, detectLevelSel,
                voltMonitorOn, wdogRunning, countSourceLow}));
            rd(`WDO_IDX_RESET_OPT, 32'(ro));
            rd(`WDO_IDX_WDOG_OPT, 32'(wo));
            rd(`WDO_IDX_ACTION, 32'({~ro[7], 2'b00}));
        end
        bus(1, `WDO_IDX_RESET_OPT, 32'h00);
        rd(`WDO_IDX_RESET_OPT, 32'(ro));
        rd(16'h0007, 32'h0);
        $display("option decode test done");
        boot(8'hFF, 8'hF0, 0);
        avsByteenable <= 4'hE;
        bus(1, `WDO_IDX_ACTION, 32'h04);
        avsByteenable <= 4'hF;
        rd(`WDO_IDX_ACTION, 32'h0);
        bus(1, `WDO_IDX_PROTECT, 32'h80);
        rd(`WDO_IDX_PROTECT, 32'h0);
        bus(1, `WDO_IDX_PROTECT, 32'h00);
        bus(1, `WDO_IDX_PROTECT, 32'h80);
        bus(1, `WDO_IDX_PROTECT, 32'h00);
        rd(`WDO_IDX_PROTECT, 32'h80);
        rd(`WDO_IDX_ACTION, 32'h04);
        chk("source", 32'h1, 32'(countSourceLow));
        bus(1, `WDO_IDX_START, 32'h0);
        bus(1, `WDO_IDX_REFRESH, 32'h00);
        bus(1, `WDO_IDX_REFRESH, 32'hFF);
        @(posedge clock);
        chk("reset request", 32'h1, 32'(wdogResetReq));
        @(posedge clock);
        chk("reset request", 32'h0, 32'(wdogResetReq));
        $display("protection test done");
        boot(8'hFF, 8'hF0, 0);
        bus(1, `WDO_IDX_MASK, 32'h3);
        bus(1, `WDO_IDX_START, 32'h0);
        t0 = cyc;
        rd(`WDO_IDX_STATUS, 32'h0);
        chk("running", 32'h1, 32'(wdogRunning));
        // Refresh just after start lies outside the 25% window
        bus(1, `WDO_IDX_REFRESH, 32'h00);
        bus(1, `WDO_IDX_REFRESH, 32'hFF);
        rd(`WDO_IDX_STATUS, 32'h2);
        chk("irq", 32'h1, 32'(irq));
        bus(1, `WDO_IDX_MASK, 32'h1);
        bus(1, `WDO_IDX_STATUS, 32'h2);
        rd(`WDO_IDX_STATUS, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        while (irq !== 1'b1) @(posedge clock);
        chk("period", 32'h1, 32'((cyc - t0) inside {[16300:16450]}));
        rd(`WDO_IDX_STATUS, 32'h1);
        $display("count test done");
        end_sim();
    end
endmodule

/* File: tb/wdo_option_checker.sv */
// Checker of the watchdog option block: bus handshake and option decoding.
// Assumes option pins and erase flags change only while rst_n is low.
`timescale 1ns/100ps
`include "wdo_params.svh"
module wdo_option_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitrequest,
    input wire logic [7:0] resetOptionPin,
    input wire logic [7:0] watchdogOptionPin,
    input wire logic resetOptErased,
    input wire logic wdogOptErased,
    input wire logic countSourceLow,
    input wire logic [13:0] reloadCount,
    input wire logic [1:0] refreshWindowSel,
    input wire logic codeProtectOn,
    input wire logic [1:0] detectLevelSel,
    input wire logic voltMonitorOn,
    input wire logic wdogRunning
);
    localparam logic [13:0] RL [4] = '{`WDO_RELOAD_0, `WDO_RELOAD_1, `WDO_RELOAD_2, `WDO_RELOAD_3};
    logic [7:0] ro;
    logic [7:0] wo;
    logic act;
    // Erase wins over the pins, so the checker folds it in the same way
    assign ro = resetOptErased ? 8'hFF : resetOptionPin;
    assign wo = wdogOptErased ? 8'hFF : watchdogOptionPin;
    // Every reload value is nonzero, so this marks the latched phase
    assign act = reloadCount != 14'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_wait_one; !avsWaitrequest |=> avsWaitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");
    property p_answer; (avsRead || avsWrite) && avsWaitrequest && act |=> !avsWaitrequest; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_reload; act |-> reloadCount == RL[wo[1:0]]; endproperty
    a_reload: assert property (p_reload) else $error("reload count wrong");
    property p_window; act |-> refreshWindowSel == wo[3:2]; endproperty
    a_window: assert property (p_window) else $error("window select wrong");
    property p_cprot; act |-> codeProtectOn == (ro[2] && !ro[3]); endproperty
    a_cprot: assert property (p_cprot) else $error("code protect wrong");
    property p_level; act |-> detectLevelSel == ro[5:4]; endproperty
    a_level: assert property (p_level) else $error("detect level wrong");
    property p_vmon; act |-> voltMonitorOn == !ro[6]; endproperty
    a_vmon: assert property (p_vmon) else $error("voltage monitor wrong");
    property p_autostart; $rose(act) |-> wdogRunning == !ro[0]; endproperty
    a_autostart: assert property (p_autostart) else $error("auto start wrong");
    property p_source; $rose(act) |-> countSourceLow == !ro[7]; endproperty
    a_source: assert property (p_source) else $error("protect after reset wrong");
    property p_keep; !$fell(countSourceLow); endproperty
    a_keep: assert property (p_keep) else $error("protection cleared");
    c_soft_protect: cover property ($rose(countSourceLow) && ro[7]);
    c_start: cover property ($rose(wdogRunning) && ro[0]);
    c_write: cover property (avsWrite && !avsWaitrequest);
endmodule

bind wdo_option_config wdo_option_checker uCheck (.clock, .rst_n, .avsRead, .avsWrite,
    .avsWaitrequest, .resetOptionPin, .watchdogOptionPin, .resetOptErased, .wdogOptErased,
    .countSourceLow, .reloadCount, .refreshWindowSel, .codeProtectOn, .detectLevelSel,
    .voltMonitorOn, .wdogRunning);

/* File: verilog/wdo_option_config.sv */
// Watchdog configuration: option bytes, count source protection, counter and window check.
// Assumes option bytes arrive as flash pins and the low-speed oscillator as a pin level.
`timescale 1ns/100ps
`include "wdo_params.svh"

module wdo_option_config import wdo_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [17:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic [7:0] resetOptionPin,
    input wire logic [7:0] watchdogOptionPin,
    input wire logic resetOptErased,
    input wire logic wdogOptErased,
    input wire logic lowSpeedClkPin,
    output logic irq,
    output logic wdogResetReq,
    output logic countSourceLow,
    output logic [13:0] reloadCount,
    output logic [1:0] refreshWindowSel,
    output logic codeProtectOn,
    output logic [1:0] detectLevelSel,
    output logic voltMonitorOn,
    output logic wdogRunning
);

    // Two sync cycles and one latch cycle pass before the bus is served
    wdo_state_t state_q, state_d;
    logic [7:0] rOpt1_q, rOpt2_q, wOpt1_q, wOpt2_q;
    logic [1:0] blank1_q, blank2_q;
    logic ls1_q, ls2_q, ls3_q;
    logic [7:0] rOpt_q, rOpt_d, wOpt_q, wOpt_d;
    logic protect_q, protect_d, arm_q, arm_d, action_q, action_d;
    logic refArm_q, refArm_d, running_q, running_d;
    logic [3:0] pre_q, pre_d;
    wdo_count_t cnt_q, cnt_d, reload_q, reload_d;
    logic [1:0] status_q, status_d, mask_q, mask_d;
    logic irq_q, irq_d, rstReq_q, rstReq_d;
    logic codeProt_q, codeProt_d, vmon_q, vmon_d;
    logic waitReq_q, waitReq_d;
    logic [31:0] rdata_q, rdata_d, rdMux;
    logic [15:0] idx;
    logic [7:0] wByte, erasedR, erasedW;
    logic wrDo, tick, inWindow;
    logic [1:0] evSet, evClr;

    assign idx = avsAddress[17:2];
    assign wByte = avsWritedata[7:0];
    assign wrDo = avsWrite && !waitReq_q && avsByteenable[0];
    // An erased block reads all ones, whatever the pins show
    assign erasedR = blank1_q[1] ? `WDO_ERASED : rOpt2_q;
    assign erasedW = blank2_q[1] ? `WDO_ERASED : wOpt2_q;

    // Window ends at underflow, so it is the last fraction of the count
    always_comb begin
        unique case (wOpt_q[`WDO_WO_WINDOW_HI:`WDO_WO_WINDOW_LO])
            2'b00: inWindow = cnt_q <= (reload_q >> 2);
            2'b01: inWindow = cnt_q <= (reload_q >> 1);
            2'b10: inWindow = cnt_q <= (reload_q - (reload_q >> 2));
            2'b11: inWindow = 1'b1;
        endcase
    end

    // Reserved bits and unmapped indices read zero
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (idx)
            `WDO_IDX_PROTECT: rdMux[`WDO_PROTECT_BIT] = protect_q;
            `WDO_IDX_ACTION: rdMux[`WDO_ACTION_BIT] = action_q;
            `WDO_IDX_STATUS: rdMux[1:0] = status_q;
            `WDO_IDX_MASK: rdMux[1:0] = mask_q;
            `WDO_IDX_COUNT: rdMux[13:0] = cnt_q;
            `WDO_IDX_WDOG_OPT: rdMux[7:0] = wOpt_q;
            `WDO_IDX_RESET_OPT: rdMux[7:0] = rOpt_q;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Protected mode counts oscillator rising edges sampled on clock; otherwise every clock counts
    // Oscillator pulses shorter than one clock can be lost in the synchroniser
    assign tick = protect_q ? (ls2_q && !ls3_q) : 1'b1;

    always_comb begin
        state_d = state_q;
        rOpt_d = rOpt_q;
        wOpt_d = wOpt_q;
        protect_d = protect_q;
        arm_d = arm_q;
        action_d = action_q;
        refArm_d = refArm_q;
        running_d = running_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        reload_d = reload_q;
        mask_d = mask_q;
        codeProt_d = codeProt_q;
        vmon_d = vmon_q;
        rstReq_d = 1'b0;
        evSet = 2'b00;
        evClr = 2'b00;
        rdata_d = rdata_q;
        // Bus held off until option bytes are loaded
        // Once active, every request gets exactly one wait state
        waitReq_d = !((avsRead || avsWrite) && waitReq_q && state_q == WDO_ACTIVE);
        if ((avsRead || avsWrite) && waitReq_q && state_q == WDO_ACTIVE) begin
            rdata_d = avsRead ? rdMux : 32'h0000_0000;
        end
        unique case (state_q)
            WDO_SYNC1: state_d = WDO_SYNC2;
            WDO_SYNC2: state_d = WDO_LATCH;
            WDO_LATCH: begin
                // Option bytes are taken from flash only here, never from stores
                rOpt_d = erasedR;
                wOpt_d = erasedW;
                running_d = !erasedR[`WDO_RO_AUTOSTART];
                protect_d = !erasedR[`WDO_RO_PROTECT];
                action_d = !erasedR[`WDO_RO_PROTECT];
                codeProt_d = erasedR[`WDO_RO_CP_DISABLE] && !erasedR[`WDO_RO_CP_ENABLE];
                vmon_d = !erasedR[`WDO_RO_VMON];
                unique case (erasedW[`WDO_WO_RELOAD_HI:`WDO_WO_RELOAD_LO])
                    2'b00: reload_d = `WDO_RELOAD_0;
                    2'b01: reload_d = `WDO_RELOAD_1;
                    2'b10: reload_d = `WDO_RELOAD_2;
                    2'b11: reload_d = `WDO_RELOAD_3;
                endcase
                cnt_d = reload_d;
                state_d = WDO_ACTIVE;
            end
            WDO_ACTIVE: begin
                // Prescaler is not cleared by a refresh, so a period may end early
                if (running_q && tick) begin
                    pre_d = pre_q + 4'h1;
                    if (pre_q == `WDO_PRESCALE_LAST) begin
                        if (cnt_q == 14'h0000) begin
                            cnt_d = reload_q;
                            evSet[`WDO_ST_UNDERFLOW] = 1'b1;
                        end else begin
                            cnt_d = cnt_q - 14'h0001;
                        end
                    end
                end
                if (wrDo) begin
                    unique case (idx)
                        `WDO_IDX_PROTECT: begin
                            // Software keeps interrupts off between the two writes
                            // Arm survives other writes; only a write of 1 uses it up
                            if (!wByte[`WDO_PROTECT_BIT]) begin
                                arm_d = 1'b1;
                            end else if (arm_q) begin
                                protect_d = 1'b1;
                                action_d = 1'b1;
                                arm_d = 1'b0;
                            end
                            // A zero never clears protect_q
                        end
                        `WDO_IDX_ACTION: begin
                            // Action bit is set-only; a zero write leaves it
                            if (wByte[`WDO_ACTION_BIT]) begin
                                action_d = 1'b1;
                            end
                        end
                        `WDO_IDX_START: running_d = 1'b1;
                        `WDO_IDX_REFRESH: begin
                            // Refresh while stopped is ignored
                            // Any value other than 00h drops the arm
                            if (wByte == `WDO_REFRESH_FIRST) begin
                                refArm_d = 1'b1;
                            end else begin
                                refArm_d = 1'b0;
                                if (wByte == `WDO_REFRESH_SECOND && refArm_q && running_q) begin
                                    if (inWindow) begin
                                        cnt_d = reload_q;
                                    end else begin
                                        evSet[`WDO_ST_ILLEGAL] = 1'b1;
                                    end
                                end
                            end
                        end
                        `WDO_IDX_STATUS: evClr = wByte[1:0];
                        `WDO_IDX_MASK: mask_d = wByte[1:0];
                        `WDO_IDX_WDOG_OPT, `WDO_IDX_RESET_OPT: begin
                            // Option bytes are flash data; stores never reach them
                        end
                        default: begin
                        end
                    endcase
                end
                if (|evSet && action_q) begin
                    rstReq_d = 1'b1;
                end
            end
        endcase
        // Hardware set wins over a same-cycle clear
        status_d = (status_q & ~evClr) | evSet;
        irq_d = |(status_d & mask_d);
    end

    // Flash pins and oscillator pass two flops before any logic reads them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rOpt1_q <= 8'hFF;
            rOpt2_q <= 8'hFF;
            wOpt1_q <= 8'hFF;
            wOpt2_q <= 8'hFF;
            blank1_q <= 2'b00;
            blank2_q <= 2'b00;
            ls1_q <= 1'b0;
            ls2_q <= 1'b0;
            ls3_q <= 1'b0;
        end else begin
            rOpt1_q <= resetOptionPin;
            rOpt2_q <= rOpt1_q;
            wOpt1_q <= watchdogOptionPin;
            wOpt2_q <= wOpt1_q;
            blank1_q <= {blank1_q[0], resetOptErased};
            blank2_q <= {blank2_q[0], wdogOptErased};
            ls1_q <= lowSpeedClkPin;
            ls2_q <= ls1_q;
            ls3_q <= ls2_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= WDO_SYNC1;
            rOpt_q <= 8'hFF;
            wOpt_q <= 8'hFF;
            protect_q <= 1'b0;
            arm_q <= 1'b0;
            action_q <= 1'b0;
            refArm_q <= 1'b0;
            running_q <= 1'b0;
            pre_q <= 4'h0;
            cnt_q <= 14'h0000;
            reload_q <= 14'h0000;
            status_q <= 2'b00;
            mask_q <= 2'b00;
            irq_q <= 1'b0;
            rstReq_q <= 1'b0;
            codeProt_q <= 1'b0;
            vmon_q <= 1'b0;
            waitReq_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            rOpt_q <= rOpt_d;
            wOpt_q <= wOpt_d;
            protect_q <= protect_d;
            arm_q <= arm_d;
            action_q <= action_d;
            refArm_q <= refArm_d;
            running_q <= running_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            reload_q <= reload_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            rstReq_q <= rstReq_d;
            codeProt_q <= codeProt_d;
            vmon_q <= vmon_d;
            waitReq_q <= waitReq_d;
            rdata_q <= rdata_d;
        end
    end

    // Every output comes straight from a register
    assign avsReaddata = rdata_q;
    assign avsWaitrequest = waitReq_q;
    assign irq = irq_q;
    assign wdogResetReq = rstReq_q;
    assign countSourceLow = protect_q;
    assign reloadCount = reload_q;
    assign refreshWindowSel = wOpt_q[`WDO_WO_WINDOW_HI:`WDO_WO_WINDOW_LO];
    assign codeProtectOn = codeProt_q;
    assign detectLevelSel = rOpt_q[`WDO_RO_LEVEL_HI:`WDO_RO_LEVEL_LO];
    assign voltMonitorOn = vmon_q;
    assign wdogRunning = running_q;

endmodule

/* File: verilog/wdo_params.svh */
// Offsets, field positions, reset values and counts of the watchdog option block.
// Assumes a 32-bit Avalon-MM slave whose byte address is four times the index.
`ifndef WDO_PARAMS_SVH
`define WDO_PARAMS_SVH

`define WDO_IDX_PROTECT 16'h0000
`define WDO_IDX_ACTION 16'h0001
`define WDO_IDX_REFRESH 16'h0002
`define WDO_IDX_START 16'h0003
`define WDO_IDX_STATUS 16'h0004
`define WDO_IDX_MASK 16'h0005
`define WDO_IDX_COUNT 16'h0006
`define WDO_IDX_WDOG_OPT 16'hFFDB
`define WDO_IDX_RESET_OPT 16'hFFFF

`define WDO_RO_AUTOSTART 0
`define WDO_RO_CP_DISABLE 2
`define WDO_RO_CP_ENABLE 3
`define WDO_RO_LEVEL_LO 4
`define WDO_RO_LEVEL_HI 5
`define WDO_RO_VMON 6
`define WDO_RO_PROTECT 7
`define WDO_WO_RELOAD_LO 0
`define WDO_WO_RELOAD_HI 1
`define WDO_WO_WINDOW_LO 2
`define WDO_WO_WINDOW_HI 3

`define WDO_PROTECT_BIT 7
`define WDO_ACTION_BIT 2
`define WDO_ST_UNDERFLOW 0
`define WDO_ST_ILLEGAL 1

`define WDO_ERASED 8'hFF
`define WDO_RELOAD_0 14'h03FF
`define WDO_RELOAD_1 14'h0FFF
`define WDO_RELOAD_2 14'h1FFF
`define WDO_RELOAD_3 14'h3FFF
`define WDO_REFRESH_FIRST 8'h00
`define WDO_REFRESH_SECOND 8'hFF
`define WDO_PRESCALE_LAST 4'hF

`endif

/* File: verilog/wdo_pkg.sv */
// Types shared by the watchdog option block.
// Assumes the constants of wdo_params.svh are included where needed.
package wdo_pkg;
    typedef enum logic [1:0] {WDO_SYNC1, WDO_SYNC2, WDO_LATCH, WDO_ACTIVE} wdo_state_t;
    typedef logic [13:0] wdo_count_t;
endpackage
